// [design/drive_mode_regs.svh]
`ifndef DRIVE_MODE_REGS_SVH
`define DRIVE_MODE_REGS_SVH
// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define OFS_CTRL_WORD     8'h00
`define OFS_MODE_SEL      8'h04
`define OFS_STATUS_WORD   8'h08
`define OFS_TARGET_POS    8'h0C
`define OFS_PROF_SPEED    8'h10
`define OFS_PROF_ACCEL    8'h14
`define OFS_PROF_DECEL    8'h18
`define OFS_TARGET_VEL    8'h1C
`define OFS_MOTION_STAT   8'h20
`define OFS_IRQ_STATUS    8'h24
`define OFS_IRQ_ENABLE    8'h28
`define OFS_IRQ_CLEAR     8'h2C
`define OFS_ACTIVE_TGT    8'h30
// ***************************************************************
// control word bits
// ***************************************************************
`define CW_NEW_SETPOINT   4
`define CW_IMMEDIATE      5
`define CW_RELATIVE       6
`define CW_HALT           8
`define CW_CHANGE_ON_SP   9
// ***************************************************************
// status word bits and codes
// ***************************************************************
`define SW_TARGET_REACHED 10
`define SW_SP_ACK         12
`define SW_FOLLOW_ERR     13
`define ST_SW_DISABLED    8'h50
`define ST_READY          8'h31
`define ST_SWITCHED_ON    8'h33
`define ST_OP_ENABLED     8'h37
`define CW_DISABLE        16'h0000
`define CW_SHUTDOWN       16'h0006
`define CW_SWITCH_ON      16'h0007
`define CW_ENABLE_OP      16'h000F
`define CW_STATE_MASK     16'h008F
`define MODE_POSITION     8'h01
`define MODE_VELOCITY     8'h03
// ***************************************************************
// reset values
// ***************************************************************
`define RST_CTRL_WORD     16'h0000
`define RST_MODE_SEL      8'h00
`endif

// [design/drive_mode_pkg.sv]
package drive_mode_pkg;
   // drive state machine states
   typedef enum logic [1:0] {
      st_sw_disabled,
      st_ready,
      st_switched_on,
      st_op_enabled
   } drive_state_t;
   // position move sequencer
   typedef enum logic [1:0] {
      mv_idle,
      mv_moving,
      mv_halting
   } move_state_t;
endpackage

// [design/drive_motion_mode_control.sv]
`timescale 1ns/1ns
`include "drive_mode_regs.svh"
module drive_motion_mode_control
   import drive_mode_pkg::*;
#(
   parameter int POS_W = 32
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic [POS_W-1:0] actual_pos,
   input wire logic target_reached_in,
   input wire logic at_standstill,
   input wire logic follow_err_in,
   output logic [POS_W-1:0] move_target,
   output logic move_start,
   output logic move_blend,
   output logic move_stop,
   output logic speed_profile_operation,
   output logic [31:0] apply_speed,
   output logic [31:0] apply_accel,
   output logic [31:0] apply_decel,
   output logic irq
);
   // ***************************************************************
   // registers
   // ***************************************************************
   logic [15:0] ctrl_word;
   logic [7:0] mode_sel;
   logic [POS_W-1:0] target_pos;
   logic [31:0] prof_speed;
   logic [31:0] prof_accel;
   logic [31:0] prof_decel;
   logic [31:0] target_vel;
   logic [3:0] irq_status;
   logic [3:0] irq_enable;
   drive_state_t dstate;
   drive_state_t next_dstate;
   move_state_t mstate;
   logic nsp_prev;
   logic sp_ack;
   logic pend_valid;
   logic [POS_W-1:0] pend_target;
   logic pend_blend;
   logic [15:0] status_word;
   logic [3:0] events;

   function automatic logic wr_hit(input logic [7:0] ofs);
      return wr_en && (addr == ofs);
   endfunction

   // target resolution: bit 6 selects relative to present position, or to the active target for a queued move
   function automatic logic [POS_W-1:0] resolve(input logic rel,
         input logic [POS_W-1:0] tgt, input logic [POS_W-1:0] base);
      return rel ? tgt + base : tgt;
   endfunction

   wire logic op_en = (dstate == st_op_enabled);
   wire logic pos_mode = (mode_sel == `MODE_POSITION);
   wire logic nsp_rise = ctrl_word[`CW_NEW_SETPOINT] && !nsp_prev;
   wire logic halt = ctrl_word[`CW_HALT];

   // ***************************************************************
   // register writes
   // ***************************************************************
   // control word: the PLC drives the state machine through it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_word <= `RST_CTRL_WORD;
      end else if (wr_hit(`OFS_CTRL_WORD)) begin
         ctrl_word <= wdata[15:0];
      end
   end

   // mode change is refused while operation is enabled, since a
   // switch under a running profile could leave the axis unsafe
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_sel <= `RST_MODE_SEL;
      end else if (wr_hit(`OFS_MODE_SEL) && !op_en) begin
         mode_sel <= wdata[7:0];
      end
   end

   // profile entries hold until rewritten
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         target_pos <= '0;
         prof_speed <= '0;
         prof_accel <= '0;
         prof_decel <= '0;
         target_vel <= '0;
      end else begin
         if (wr_hit(`OFS_TARGET_POS)) target_pos <= wdata[POS_W-1:0];
         if (wr_hit(`OFS_PROF_SPEED)) prof_speed <= wdata;
         if (wr_hit(`OFS_PROF_ACCEL)) prof_accel <= wdata;
         if (wr_hit(`OFS_PROF_DECEL)) prof_decel <= wdata;
         if (wr_hit(`OFS_TARGET_VEL)) target_vel <= wdata;
      end
   end

   // ***************************************************************
   // drive state machine
   // ***************************************************************
   // states follow the masked command; unknown words keep state
   always_comb begin
      next_dstate = dstate;
      case (ctrl_word & `CW_STATE_MASK)
         `CW_DISABLE: next_dstate = st_sw_disabled;
         `CW_SHUTDOWN: next_dstate = st_ready;
         `CW_SWITCH_ON: begin
            if (dstate != st_sw_disabled) begin
               next_dstate = st_switched_on;
            end
         end
         `CW_ENABLE_OP: begin
            if (dstate == st_switched_on || dstate == st_op_enabled) begin
               next_dstate = st_op_enabled;
            end
         end
         default: next_dstate = dstate;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dstate <= st_sw_disabled;
      end else begin
         dstate <= next_dstate;
      end
   end

   // ***************************************************************
   // speed profile outputs, velocity and position mode
   // ***************************************************************
   // ramps follow the retained entries at once; speed does too, but is zero while halted or outside operation enabled
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         speed_profile_operation <= 1'b0;
         apply_speed <= '0;
         apply_accel <= '0;
         apply_decel <= '0;
      end else begin
         speed_profile_operation <= (next_dstate == st_op_enabled) &&
            (mode_sel == `MODE_VELOCITY);
         apply_speed <= (halt || !op_en) ? 32'h0000_0000 :
            (pos_mode ? prof_speed : target_vel);
         apply_accel <= prof_accel;
         // no separate decel entry falls back to acceleration
         apply_decel <= (prof_decel != 32'h0000_0000) ?
            prof_decel : prof_accel;
      end
   end

   // ***************************************************************
   // position set-point handshake
   // ***************************************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         nsp_prev <= 1'b0;
      end else begin
         nsp_prev <= ctrl_word[`CW_NEW_SETPOINT];
      end
   end

   // acknowledge drops once the PLC lowers new-set-point
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sp_ack <= 1'b0;
      end else if (!op_en || !pos_mode) begin
         sp_ack <= 1'b0;
      end else if (nsp_rise && !sp_ack && !halt) begin
         sp_ack <= 1'b1;
      end else if (!ctrl_word[`CW_NEW_SETPOINT]) begin
         sp_ack <= 1'b0;
      end
   end

   // move sequencer; a pending move waits one slot deep
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mstate <= mv_idle;
         pend_valid <= 1'b0;
         pend_target <= '0;
         pend_blend <= 1'b0;
         move_target <= '0;
         move_start <= 1'b0;
         move_blend <= 1'b0;
         move_stop <= 1'b0;
      end else begin
         move_start <= 1'b0;
         if (!op_en || !pos_mode) begin
            mstate <= mv_idle;
            pend_valid <= 1'b0;
            move_stop <= 1'b0;
         end else begin
            case (mstate)
               mv_idle: begin
                  move_stop <= 1'b0;
                  if (halt) begin
                     move_stop <= 1'b1;
                  end else if (nsp_rise && !sp_ack) begin
                     move_target <= resolve(ctrl_word[`CW_RELATIVE],
                        target_pos, actual_pos);
                     move_blend <= 1'b0;
                     move_start <= 1'b1;
                     mstate <= mv_moving;
                  end else if (pend_valid) begin
                     move_target <= pend_target;
                     move_blend <= pend_blend;
                     move_start <= 1'b1;
                     pend_valid <= 1'b0;
                     mstate <= mv_moving;
                  end
               end
               mv_moving: begin
                  if (halt) begin
                     move_stop <= 1'b1;
                     mstate <= mv_halting;
                  end else if (nsp_rise && !sp_ack &&
                        ctrl_word[`CW_IMMEDIATE]) begin
                     move_target <= resolve(ctrl_word[`CW_RELATIVE],
                        target_pos, actual_pos);
                     move_blend <= 1'b0;
                     move_start <= 1'b1;
                  end else if (nsp_rise && !sp_ack) begin
                     pend_valid <= 1'b1;
                     pend_target <= resolve(ctrl_word[`CW_RELATIVE],
                        target_pos, move_target);
                     pend_blend <= ctrl_word[`CW_CHANGE_ON_SP];
                  end else if (target_reached_in) begin
                     if (pend_valid) begin
                        move_target <= pend_target;
                        move_blend <= pend_blend;
                        move_start <= 1'b1;
                        pend_valid <= 1'b0;
                     end else begin
                        mstate <= mv_idle;
                     end
                  end
               end
               mv_halting: begin
                  if (at_standstill) begin
                     mstate <= mv_idle;
                  end
               end
               default: mstate <= mv_idle;
            endcase
         end
      end
   end

   // ***************************************************************
   // status word and interrupts
   // ***************************************************************
   // low byte carries the state code; high bits mode specific
   always_comb begin
      status_word = 16'h0000;
      case (dstate)
         st_sw_disabled: status_word[7:0] = `ST_SW_DISABLED;
         st_ready: status_word[7:0] = `ST_READY;
         st_switched_on: status_word[7:0] = `ST_SWITCHED_ON;
         st_op_enabled: status_word[7:0] = `ST_OP_ENABLED;
         default: status_word[7:0] = `ST_SW_DISABLED;
      endcase
      if (op_en && pos_mode) begin
         status_word[`SW_TARGET_REACHED] = halt ? at_standstill :
            (mstate == mv_idle && !pend_valid);
         status_word[`SW_SP_ACK] = sp_ack;
         status_word[`SW_FOLLOW_ERR] = follow_err_in;
      end
   end

   // events: new set-point rise without ack pending, target reached, follow error, state change
   assign events = {next_dstate != dstate, follow_err_in,
      status_word[`SW_TARGET_REACHED], nsp_rise && !sp_ack};

   // a new event wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq_status <= 4'h0;
         irq_enable <= 4'h0;
      end else begin
         irq_status <= (irq_status &
            ~(wr_hit(`OFS_IRQ_CLEAR) ? wdata[3:0] : 4'h0)) | events;
         if (wr_hit(`OFS_IRQ_ENABLE)) irq_enable <= wdata[3:0];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_enable);
      end
   end

   // ***************************************************************
   // read mux, data one cycle after the strobe
   // ***************************************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd_en) begin
         case (addr)
            `OFS_CTRL_WORD: rdata <= {16'h0000, ctrl_word};
            `OFS_MODE_SEL: rdata <= {24'h000000, mode_sel};
            `OFS_STATUS_WORD: rdata <= {16'h0000, status_word};
            `OFS_TARGET_POS: rdata <= 32'(target_pos);
            `OFS_PROF_SPEED: rdata <= prof_speed;
            `OFS_PROF_ACCEL: rdata <= prof_accel;
            `OFS_PROF_DECEL: rdata <= prof_decel;
            `OFS_TARGET_VEL: rdata <= target_vel;
            `OFS_MOTION_STAT: rdata <= {29'h0, pend_valid, mstate};
            `OFS_IRQ_STATUS: rdata <= {28'h0000000, irq_status};
            `OFS_IRQ_ENABLE: rdata <= {28'h0000000, irq_enable};
            `OFS_ACTIVE_TGT: rdata <= 32'(move_target);
            default: rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

endmodule

// [testbench/drive_mode_chk_sva.sv]
`timescale 1ns/1ns
// ***
// port checker for the drive control block
// ***
module drive_mode_chk #(parameter int POS_W = 32) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic target_reached_in,
   input wire logic move_start,
   input wire logic move_blend,
   input wire logic move_stop,
   input wire logic speed_profile_operation,
   input wire logic [31:0] apply_accel,
   input wire logic [31:0] apply_decel
);
   logic [15:0] cw_q;
   logic [7:0] mode_q;
   wire cw_wr = wr_en && addr == 8'h00;
   wire was_en = (cw_q & 16'h008F) == 16'h000F;
   wire sp_wr = cw_wr && wdata[4] && !cw_q[4];
   wire en_pos = was_en && mode_q == 8'h01;
   // shadow of control and mode; assumes a legal start-up order
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cw_q <= 16'h0000;
         mode_q <= 8'h00;
      end else begin
         if (cw_wr) begin
            cw_q <= wdata[15:0];
         end
         if (wr_en && addr == 8'h04 && !was_en) begin
            mode_q <= wdata[7:0];
         end
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   start_pulse_a: assert property (move_start |=> !move_start)
      else $error("move start wider than one cycle");
   start_cause_a: assert property (move_start |->
      $past(sp_wr, 2) || $past(target_reached_in) ||
      $past(target_reached_in, 2))
      else $error("move start without cause");
   sp_now_a: assert property (sp_wr && wdata[5] && !wdata[8] &&
      en_pos |-> ##2 move_start)
      else $error("immediate set-point not started");
   vel_no_start_a: assert property (sp_wr && mode_q == 8'h03
      |-> ##2 !move_start)
      else $error("move started in velocity mode");
   halt_no_start_a: assert property (sp_wr && wdata[8]
      |-> ##2 !move_start)
      else $error("move started while halted");
   halt_stop_a: assert property (cw_wr && wdata[8] && en_pos
      |-> ##[1:3] move_stop)
      else $error("halt not applied");
   decel_fallback_a: assert property (apply_decel == 32'h0
      |-> apply_accel == 32'h0)
      else $error("zero decel not replaced by accel");
   disable_drop_a: assert property (cw_wr &&
      (wdata[15:0] & 16'h008F) == 16'h0000
      |-> ##[1:3] !speed_profile_operation)
      else $error("velocity run kept after disable");
   vel_enable_a: assert property (cw_wr && wdata[15:0] == 16'h000F &&
      cw_q == 16'h0007 && mode_q == 8'h03
      |-> ##[1:3] speed_profile_operation)
      else $error("velocity run not entered");
   cover property (move_start && move_blend);
   cover property ($rose(move_stop));
   cover property ($rose(speed_profile_operation));
endmodule

// [testbench/motor_model.sv]
`timescale 1ns/1ns
// ***
// axis model behind the move interface
// ***
module motor_model #(parameter int POS_W = 32) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [7:0] dly,
   input wire logic [POS_W-1:0] move_target,
   input wire logic move_start,
   input wire logic move_stop,
   output logic [POS_W-1:0] actual_pos,
   output logic target_reached_in,
   output logic at_standstill
);
   logic [7:0] cnt;
   logic [POS_W-1:0] goal;
   // a move lasts dly cycles; halt freezes it, a new start restarts it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 8'h00;
         goal <= '0;
         actual_pos <= '0;
      end else if (move_start) begin
         cnt <= dly;
         goal <= move_target;
      end else if (cnt != 8'h00 && !move_stop) begin
         cnt <= cnt - 8'h01;
         if (cnt == 8'h01) begin
            actual_pos <= goal;
         end
      end
   end
   // a start pulse hides the idle count until the new move loads,
   // else the sequencer would see the old move as just finished
   assign target_reached_in = cnt == 8'h00 && !move_start;
   assign at_standstill = (cnt == 8'h00 && !move_start) ||
      move_stop;
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic follow_err_in = 1'b0;
   logic [7:0] dly = 8'h04;
   logic [31:0] rdata, move_target, actual_pos, apply_speed, last_tgt;
   logic [31:0] apply_accel, apply_decel;
   logic target_reached_in, at_standstill, move_start, move_blend;
   logic move_stop, speed_profile_operation, irq, last_blend;
   int err_total = 0;
   int total_checks = 0;
   int n_start = 0;
   int cyc = 0;
   drive_motion_mode_control i_dut (.clk_sys, .arst_n, .addr, .wdata,
      .wr_en, .rd_en, .rdata, .actual_pos, .target_reached_in,
      .at_standstill, .follow_err_in, .move_target, .move_start,
      .move_blend, .move_stop, .speed_profile_operation, .apply_speed,
      .apply_accel, .apply_decel, .irq);
   motor_model i_motor (.clk_sys, .arst_n, .dly, .move_target,
      .move_start, .move_stop, .actual_pos, .target_reached_in,
      .at_standstill);
   always #4 clk_sys = ~clk_sys;
   // ***
   // move log and hang guard, sampled mid-cycle to avoid races
   // ***
   always @(negedge clk_sys) begin
      cyc++;
      if (move_start === 1'b1) begin
         n_start++;
         last_tgt = move_target;
         last_blend = move_blend;
      end
      if (cyc == 5000) begin
         err_total++;
         final_report();
      end
   end
   task automatic final_report();
      if (err_total == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // register bus: one-cycle strobes, read data in the next cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      @(posedge clk_sys);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic waitn(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // ***
   // scenarios
   // ***
   task automatic t_velocity();
      wr(8'h00, 32'h0);
      rc(8'h08, 32'hFF, 32'h50);
      wr(8'h04, 32'h3);
      wr(8'h00, 32'h6);
      rc(8'h08, 32'hFF, 32'h31);
      wr(8'h00, 32'h7);
      rc(8'h08, 32'hFF, 32'h33);
      wr(8'h10, 32'h111);
      wr(8'h14, 32'h333);
      wr(8'h18, 32'h444);
      wr(8'h1C, 32'h222);
      wr(8'h00, 32'hF);
      rc(8'h08, 32'hFF, 32'h37);
      chk(speed_profile_operation, 32'h1);
      chk(apply_speed, 32'h222);
      chk(apply_decel, 32'h444);
      wr(8'h00, 32'h1F);
      settle();
      chk(n_start, 32'h0);
      wr(8'h00, 32'hF);
      wr(8'h14, 32'h555);
      settle();
      chk(apply_accel, 32'h555);
      chk(apply_speed, 32'h222);
      rc(8'h10, 32'hFFFFFFFF, 32'h111);
      wr(8'h18, 32'h0);
      settle();
      chk(apply_decel, 32'h555);
   endtask
   task automatic t_mode();
      wr(8'h04, 32'h1);
      rc(8'h04, 32'hFF, 32'h3);
      wr(8'h00, 32'h7);
      rc(8'h08, 32'hFF, 32'h33);
      wr(8'h04, 32'h1);
      rc(8'h04, 32'hFF, 32'h1);
      wr(8'h00, 32'hF);
      rc(8'h08, 32'hFF, 32'h37);
      chk(speed_profile_operation, 32'h0);
   endtask
   task automatic t_position();
      wr(8'h0C, 32'h100);
      wr(8'h00, 32'h1F);
      settle();
      chk(last_tgt, 32'h100);
      rc(8'h08, 32'h1000, 32'h1000);
      wr(8'h00, 32'hF);
      rc(8'h08, 32'h1000, 32'h0);
      waitn(10);
      wr(8'h0C, 32'h20);
      wr(8'h00, 32'h5F);
      settle();
      chk(last_tgt, 32'h120);
      wr(8'h00, 32'hF);
      waitn(10);
      dly <= 8'h28;
      wr(8'h0C, 32'h300);
      wr(8'h00, 32'h1F);
      wr(8'h00, 32'hF);
      wr(8'h0C, 32'h400);
      wr(8'h00, 32'h1F);
      settle();
      chk(n_start, 32'h3);
      wr(8'h00, 32'hF);
      waitn(50);
      chk(last_tgt, 32'h400);
      chk(last_blend, 32'h0);
      wr(8'h0C, 32'h500);
      wr(8'h00, 32'h3F);
      settle();
      chk(n_start, 32'h5);
      wr(8'h00, 32'hF);
      waitn(50);
      wr(8'h0C, 32'h600);
      wr(8'h00, 32'h21F);
      wr(8'h00, 32'h20F);
      wr(8'h0C, 32'h700);
      wr(8'h00, 32'h21F);
      wr(8'h00, 32'h20F);
      waitn(50);
      chk(last_tgt, 32'h700);
      chk(last_blend, 32'h1);
      wr(8'h00, 32'hF);
      waitn(50);
   endtask
   task automatic t_halt();
      wr(8'h00, 32'h10F);
      settle();
      chk(move_stop, 32'h1);
      chk(apply_speed, 32'h0);
      wr(8'h00, 32'h11F);
      settle();
      chk(n_start, 32'h7);
      wr(8'h00, 32'hF);
      settle();
      chk(move_stop, 32'h0);
   endtask
   task automatic t_irq();
      wr(8'h28, 32'h4);
      follow_err_in <= 1'b1;
      settle();
      rc(8'h08, 32'h2000, 32'h2000);
      chk(irq, 32'h1);
      @(posedge clk_sys);
      follow_err_in <= 1'b0;
      wr(8'h2C, 32'h4);
      settle();
      chk(irq, 32'h0);
      rc(8'h24, 32'h4, 32'h0);
      rc(8'hFC, 32'hFFFFFFFF, 32'h0);
      wr(8'h00, 32'h0);
      rc(8'h08, 32'hFF, 32'h50);
   endtask
   // reset for three cycles, then the scenarios in turn
   initial begin
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_velocity();
      t_mode();
      t_position();
      t_halt();
      t_irq();
      final_report();
   end
endmodule
bind drive_motion_mode_control drive_mode_chk #(.POS_W(POS_W)) i_chk (
   .clk_sys, .arst_n, .addr, .wdata, .wr_en, .target_reached_in,
   .move_start, .move_blend, .move_stop, .speed_profile_operation,
   .apply_accel, .apply_decel);
